// ### core/epi_pkg.sv
// Package: register map, field layout, reset values and carrier structs of the pin detector
package epi_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] PIN_REQUEST_STATUS_CONTROL_OFS = 8'h00;

  // Bit positions inside the status and control word
  localparam int BIT_EDGE_LEVEL_MODE = 0;
  localparam int BIT_HW_REQ_ENABLE = 1;
  localparam int BIT_REQ_ACK = 2;
  localparam int BIT_EVENT_PENDING = 3;
  localparam int BIT_PIN_FUNC_ENABLE = 4;
  localparam int BIT_POLARITY_SELECT = 5;
  localparam int BIT_PULL_DEV_DISABLE = 6;
  localparam int BIT_PIN_LEVEL = 7;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic pullDeviceDisable;
    logic polaritySelect;
    logic pinFunctionEnable;
    logic hardwareRequestEnable;
    logic edgeLevelMode;
  } epi_ctrl_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } epi_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } epi_apb_rsp_type;

  typedef struct packed {
    logic pullUpEn;
    logic pullDownEn;
    logic sharedFuncOff;
  } epi_pin_ctl_type;

  typedef struct packed {
    epi_ctrl_type ctrl;
    logic eventPendingFlag;
    logic activePrev;
    logic hwRequest;
    epi_pin_ctl_type pins;
    epi_apb_rsp_type rsp;
  } epi_state_type;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } epi_sync_state_type;

  // ****************************************
  // Reset values
  // ****************************************
  localparam epi_ctrl_type CTRL_RST = '0;
  localparam epi_state_type STATE_RST = '0;
  localparam epi_sync_state_type SYNC_RST = '0;

endpackage

// ### core/epi_sync.sv
// Two-stage synchroniser for the external request pin
`timescale 1ns/1ps

module epi_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Asynchronous pin and its synchronised copy
  input wire logic asyncIn,
  output logic syncOut
);

  epi_pkg::epi_sync_state_type st_r;
  epi_pkg::epi_sync_state_type st_nxt;

  // Next state; first stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.stage1 = asyncIn;
    st_nxt.stage2 = st_r.stage1;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= epi_pkg::SYNC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign syncOut = st_r.stage2;

endmodule // epi_sync

// ### core/epi_top.sv
// External interrupt pin detector with APB status and control register
`timescale 1ns/1ps

module epi_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire epi_pkg::epi_apb_req_type apbReq,
  output epi_pkg::epi_apb_rsp_type apbRsp,
  // External request pin
  input wire logic irqPinIn,
  // Pad control and processor request
  output epi_pkg::epi_pin_ctl_type pinCtl,
  output logic hwIrqReq
);

  // ****************************************
  // Declarations
  // ****************************************
  epi_pkg::epi_state_type st_r;
  epi_pkg::epi_state_type st_nxt;
  logic pinLevel;
  logic activeNow;
  logic edgeNow;
  logic eventNow;
  logic addrHit;
  logic accessDone;
  logic wrHit;
  logic ackWrite;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  epi_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .asyncIn(irqPinIn),
    .syncOut(pinLevel)
  );

  // ****************************************
  // Event detection
  // ****************************************
  // Active level folds polarity in, so one edge detector serves both senses
  assign activeNow = st_r.ctrl.polaritySelect ? pinLevel : ~pinLevel;
  assign edgeNow = activeNow & ~st_r.activePrev;
  // Level term keeps firing while the pin stays active
  assign eventNow = st_r.ctrl.pinFunctionEnable
    & (edgeNow | (st_r.ctrl.edgeLevelMode & activeNow));

  // Bus decode; writes land only at the completing edge
  assign addrHit = (apbReq.paddr == epi_pkg::PIN_REQUEST_STATUS_CONTROL_OFS);
  assign accessDone = apbReq.psel & apbReq.penable & st_r.rsp.pready;
  assign wrHit = accessDone & apbReq.pwrite & addrHit;
  assign ackWrite = wrHit & apbReq.pwdata[epi_pkg::BIT_REQ_ACK];

  // ****************************************
  // Next-state logic
  // ****************************************
  // Event detection uses the settings held before a same-cycle write; request mask and pad control use the written ones
  always_comb begin
    logic [31:0] rdWord;
    rdWord = 32'h0000_0000;
    st_nxt = st_r;
    rdWord[epi_pkg::BIT_EDGE_LEVEL_MODE] = st_r.ctrl.edgeLevelMode;
    rdWord[epi_pkg::BIT_HW_REQ_ENABLE] = st_r.ctrl.hardwareRequestEnable;
    rdWord[epi_pkg::BIT_EVENT_PENDING] = st_r.eventPendingFlag;
    rdWord[epi_pkg::BIT_PIN_FUNC_ENABLE] = st_r.ctrl.pinFunctionEnable;
    rdWord[epi_pkg::BIT_POLARITY_SELECT] = st_r.ctrl.polaritySelect;
    rdWord[epi_pkg::BIT_PULL_DEV_DISABLE] = st_r.ctrl.pullDeviceDisable;
    rdWord[epi_pkg::BIT_PIN_LEVEL] = pinLevel;
    st_nxt.activePrev = activeNow;
    // One wait state: ready rises in the second access cycle
    st_nxt.rsp.pready = apbReq.psel & apbReq.penable & ~st_r.rsp.pready;
    st_nxt.rsp.pslverr = st_nxt.rsp.pready & ~addrHit;
    st_nxt.rsp.prdata = 32'h0000_0000;
    if (st_nxt.rsp.pready & ~apbReq.pwrite & addrHit) begin
      st_nxt.rsp.prdata = rdWord;
    end
    if (wrHit) begin
      st_nxt.ctrl.edgeLevelMode = apbReq.pwdata[epi_pkg::BIT_EDGE_LEVEL_MODE];
      st_nxt.ctrl.hardwareRequestEnable = apbReq.pwdata[epi_pkg::BIT_HW_REQ_ENABLE];
      st_nxt.ctrl.pinFunctionEnable = apbReq.pwdata[epi_pkg::BIT_PIN_FUNC_ENABLE];
      st_nxt.ctrl.polaritySelect = apbReq.pwdata[epi_pkg::BIT_POLARITY_SELECT];
      st_nxt.ctrl.pullDeviceDisable = apbReq.pwdata[epi_pkg::BIT_PULL_DEV_DISABLE];
    end
    // Set wins over acknowledge so no event is lost
    if (ackWrite) begin
      st_nxt.eventPendingFlag = 1'b0;
    end
    if (eventNow) begin
      st_nxt.eventPendingFlag = 1'b1;
    end
    // Enable masks only the request, the flag stays pollable
    st_nxt.hwRequest = st_nxt.eventPendingFlag & st_nxt.ctrl.hardwareRequestEnable;
    // Pad control: exclusive use and polarity-matched pull
    st_nxt.pins.sharedFuncOff = st_nxt.ctrl.pinFunctionEnable;
    st_nxt.pins.pullUpEn = st_nxt.ctrl.pinFunctionEnable
      & ~st_nxt.ctrl.pullDeviceDisable & ~st_nxt.ctrl.polaritySelect;
    st_nxt.pins.pullDownEn = st_nxt.ctrl.pinFunctionEnable
      & ~st_nxt.ctrl.pullDeviceDisable & st_nxt.ctrl.polaritySelect;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= epi_pkg::STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign apbRsp = st_r.rsp;
  assign pinCtl = st_r.pins;
  assign hwIrqReq = st_r.hwRequest;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_flag_on_event: assert property (eventNow |=> st_r.eventPendingFlag)
    else $error("event did not set the pending flag");

  // Flag and request drop together, at the edge that completes the acknowledging write
  a_ack_clears_flag: assert property (
    (ackWrite && !eventNow) |=> !st_r.eventPendingFlag && !hwIrqReq)
    else $error("acknowledge did not clear the pending flag");

  a_poll_unmasked: assert property (
    (eventNow && !st_r.ctrl.hardwareRequestEnable && !wrHit)
      |=> st_r.eventPendingFlag && !hwIrqReq)
    else $error("masked event wrongly raised request or lost flag");

  a_fall_request: assert property (
    (st_r.ctrl.pinFunctionEnable && !st_r.ctrl.polaritySelect
      && st_r.ctrl.hardwareRequestEnable && !wrHit && !pinLevel && !st_r.activePrev)
      |=> hwIrqReq)
    else $error("low pin did not raise hardware request");

  a_disabled_quiet: assert property (
    (!st_r.ctrl.pinFunctionEnable && !st_r.eventPendingFlag)
      |=> !st_r.eventPendingFlag [*1] ##0 !hwIrqReq)
    else $error("flag set while pin function disabled");

  a_edge_only: assert property (
    (st_r.ctrl.pinFunctionEnable && !st_r.ctrl.edgeLevelMode && !edgeNow
      && !st_r.eventPendingFlag) |=> !st_r.eventPendingFlag)
    else $error("edge-only mode set flag without an edge");

  a_level_rearm: assert property (
    (st_r.ctrl.pinFunctionEnable && st_r.ctrl.edgeLevelMode && activeNow && ackWrite)
      |=> st_r.eventPendingFlag)
    else $error("active level did not re-set the flag after acknowledge");

  a_pad_exclusive: assert property (
    $rose(st_r.ctrl.pinFunctionEnable) |-> pinCtl.sharedFuncOff)
    else $error("shared function not disconnected on enable");

  a_pull_follows: assert property (
    pinCtl.pullUpEn |-> (!st_r.ctrl.polaritySelect && st_r.ctrl.pinFunctionEnable))
    else $error("pullup active with rising polarity or function off");

  a_pull_disable: assert property (
    st_r.ctrl.pullDeviceDisable |-> !pinCtl.pullUpEn && !pinCtl.pullDownEn)
    else $error("pull device on while disabled");

  a_pullup_low: assert property (
    (st_r.ctrl.pinFunctionEnable && !st_r.ctrl.polaritySelect
      && !st_r.ctrl.pullDeviceDisable) |-> pinCtl.pullUpEn && !pinCtl.pullDownEn)
    else $error("falling mode lacks pullup");

  a_apb_ready: assert property (
    (apbReq.psel && apbReq.penable && !apbRsp.pready) |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("slave ready not one cycle after access start");

  c_edge_event: cover property (edgeNow && st_r.ctrl.pinFunctionEnable);
  c_level_rearm: cover property (ackWrite && eventNow);
  c_hw_request: cover property ($rose(hwIrqReq));
  c_bad_address: cover property (apbRsp.pready && apbRsp.pslverr);

endmodule // epi_top

// ### tb/epi_switch_model.sv
// Push-button model that drives the external request pin
`timescale 1ns/1ps

module epi_switch_model (
  // Clock
  input wire logic mclk,
  // Switch state, active level and pad pulls
  input wire logic pressed,
  input wire logic activeHigh,
  input wire epi_pkg::epi_pin_ctl_type pinCtl,
  // Pin
  output logic pinLevel
);
  logic floatVal = 1'h0;

  // An open pin with no pull wanders, so stale levels never look valid
  always @(posedge mclk) floatVal <= ~floatVal;

  // Closed switch wins; open switch leaves the pin to the pad pulls
  assign pinLevel = pressed ? activeHigh :
    pinCtl.pullUpEn ? 1'h1 :
    pinCtl.pullDownEn ? 1'h0 : floatVal;
endmodule // epi_switch_model

// ### tb/epi_top_tb.sv
// Self-checking bench for the external request pin detector
`timescale 1ns/1ps

module epi_top_tb;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  epi_pkg::epi_apb_req_type apbReq = '0;
  epi_pkg::epi_apb_rsp_type apbRsp;
  epi_pkg::epi_pin_ctl_type pinCtl;
  logic hwIrqReq;
  logic irqPin;
  logic pressed = 1'h0;
  logic actHi = 1'h0;
  logic [31:0] seed = 32'h38;
  logic [31:0] rd;
  logic [31:0] rv;
  logic err;
  logic [7:0] ctrl;
  int err_total = 0;
  int num_checks = 0;

  // Clock
  always #10 mclk = ~mclk;

  epi_top epi_top_i (.mclk(mclk), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .irqPinIn(irqPin), .pinCtl(pinCtl), .hwIrqReq(hwIrqReq));
  epi_switch_model epi_switch_model_i (.mclk(mclk), .pressed(pressed),
    .activeHigh(actHi), .pinCtl(pinCtl), .pinLevel(irqPin));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Pads: pulls only while enabled and not disabled, direction from polarity
  function automatic epi_pkg::epi_pin_ctl_type expPads(input logic [7:0] c);
    return {c[4] & ~c[6] & ~c[5], c[4] & ~c[6] & c[5], c[4]};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; waits for pready with no bound of its own, no fixed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge mclk);
    apbReq.penable <= 1'h1;
    // Only the watchdog ends a wait that never completes
    do @(posedge mclk); while (apbRsp.pready !== 1'h1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'h0;
    apbReq.penable <= 1'h0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic give_verdict;
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    chk("hwIrqReq", 32'h0, hwIrqReq);
    chk("pinCtl", 32'h0, pinCtl);
    // Unmapped offset refused; pin level masked while floating
    apb(1'h1, 8'h04, rnd());
    chk("pslverr", 32'h1, err);
    apb(1'h0, 8'h00, 32'h0);
    chk("reg", 32'h0, rd & 32'h7F);
    // All four event kinds, random request enable and upper write bits
    for (int m = 0; m < 4; m++) begin
      rv = rnd();
      ctrl = {2'h0, m[1], 1'h1, 2'h0, rv[0], m[0]};
      actHi <= m[1];
      apb(1'h1, 8'h00, {rv[31:8], ctrl});
      waitc(5);
      chk("pinCtl", expPads(ctrl), pinCtl);
      // Stale events from the pull change are cleared first
      apb(1'h1, 8'h00, ctrl | 8'h04);
      waitc(rv[6:4]);
      pressed <= 1'h1;
      waitc(4);
      apb(1'h0, 8'h00, 32'h0);
      chk("reg", {24'h0, m[1], ctrl[6:0] | 7'h08}, rd);
      chk("hwIrqReq", ctrl[1], hwIrqReq);
      apb(1'h1, 8'h00, ctrl | 8'h04);
      waitc(2);
      apb(1'h0, 8'h00, 32'h0);
      chk("flagHeld", m[0], rd[3]);
      chk("hwIrqReq", ctrl[1] & m[0], hwIrqReq);
      pressed <= 1'h0;
      waitc(4);
      apb(1'h1, 8'h00, ctrl | 8'h04);
      apb(1'h0, 8'h00, 32'h0);
      chk("reg", {24'h0, ~m[1], ctrl[6:0]}, rd);
    end
    apb(1'h1, 8'h00, 32'h50);
    waitc(2);
    chk("pinCtl", 32'h1, pinCtl);
    // Turn off first: an edge of the wandering pin in the ack cycle would win
    apb(1'h1, 8'h00, 32'h02);
    apb(1'h0, 8'h00, 32'h0);
    chk("flagKept", 32'h0A, rd & 32'h7F);
    // Function off: wandering pin and random presses give no event
    apb(1'h1, 8'h00, 32'h06);
    for (int i = 0; i < 16; i++) begin
      rv = rnd();
      pressed <= rv[0];
      @(posedge mclk);
    end
    waitc(4);
    apb(1'h0, 8'h00, 32'h0);
    chk("reg", 32'h02, rd & 32'h7F);
    chk("hwIrqReq", 32'h0, hwIrqReq);
    give_verdict();
  end
endmodule // epi_top_tb
